// ==== hw/aos_pkg.sv ====
// Shared constants and types for the output source select block
package aos_pkg;

    // ********************
    // Register map
    // ********************
    localparam logic [7:0] SRC_CTRL_OFS = 8'h70;
    localparam logic [7:0] FMT_CTRL_OFS = 8'h71;
    localparam logic [7:0] SRC_CTRL_RST = 8'h22;
    localparam logic [7:0] FMT_CTRL_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RD = 8'h00;
    localparam int PAT_EN_BIT = 2;
    localparam int FMT_OB_BIT = 0;

    // ********************
    // Sample words
    // ********************
    localparam int SAMPLE_W = 16;
    localparam int SAMPLE_MSB = 15;
    localparam logic [15:0] SEQ_ZERO = 16'h0000;
    localparam logic [15:0] SEQ_HIGH = 16'h66A8;
    localparam logic [15:0] SEQ_LOW = 16'h9928;
    localparam logic [15:0] TC_NEG_FULL = 16'h8000;
    localparam logic [15:0] TC_MID = 16'h0000;
    localparam logic [15:0] TC_POS_FULL = 16'h7FFF;
    localparam logic [15:0] OB_NEG_FULL = 16'h0000;
    localparam logic [15:0] OB_MID = 16'h8000;
    localparam logic [15:0] OB_POS_FULL = 16'hFFFF;

    typedef struct packed {
        logic [15:0] chA;
        logic [15:0] chB;
    } aos_pair_t;

    typedef enum logic [1:0] {
        SEQ_P0 = 2'b00,
        SEQ_P1 = 2'b01,
        SEQ_P2 = 2'b11,
        SEQ_P3 = 2'b10
    } aos_seq_t;

endpackage

// ==== hw/aos_test_seq.sv ====
// Four-sample repeating test tone generator
`timescale 1ns/1ps
module aos_test_seq (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic advance,
    input wire logic restart,
    // Current word
    output logic [15:0] seqWord
);

    aos_pkg::aos_seq_t state_reg;
    aos_pkg::aos_seq_t state_next;

    // ********************
    // Sequence state
    // ********************
    always_comb begin
        state_next = state_reg;
        if (restart) begin
            state_next = aos_pkg::SEQ_P0;
        end else if (advance) begin
            case (state_reg)
                aos_pkg::SEQ_P0: state_next = aos_pkg::SEQ_P1;
                aos_pkg::SEQ_P1: state_next = aos_pkg::SEQ_P2;
                aos_pkg::SEQ_P2: state_next = aos_pkg::SEQ_P3;
                aos_pkg::SEQ_P3: state_next = aos_pkg::SEQ_P0;
                default: state_next = aos_pkg::SEQ_P0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= aos_pkg::SEQ_P0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Word for the current position
    always_comb begin
        case (state_reg)
            aos_pkg::SEQ_P0: seqWord = aos_pkg::SEQ_ZERO;
            aos_pkg::SEQ_P1: seqWord = aos_pkg::SEQ_HIGH;
            aos_pkg::SEQ_P2: seqWord = aos_pkg::SEQ_ZERO;
            aos_pkg::SEQ_P3: seqWord = aos_pkg::SEQ_LOW;
            default: seqWord = aos_pkg::SEQ_ZERO;
        endcase
    end

endmodule

// ==== hw/aos_top.sv ====
// Output data source select and sample code formatting
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps

module aos_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    // Converter core samples, two's complement
    input wire aos_pkg::aos_pair_t coreSample,
    input wire logic coreValid,
    // Link pattern select, not used by this path
    input wire logic [3:0] linkPatternSelect,
    // Words to the transport layer
    output aos_pkg::aos_pair_t linkSample,
    output logic linkValid
);

    // ********************
    // Registers
    // ********************
    logic [7:0] srcCtrl_reg;
    logic [7:0] srcCtrl_next;
    logic [7:0] fmtCtrl_reg;
    logic [7:0] fmtCtrl_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic patEn;
    logic fmtOb;
    logic unusedLink;

    assign patEn = srcCtrl_reg[aos_pkg::PAT_EN_BIT];
    assign fmtOb = fmtCtrl_reg[aos_pkg::FMT_OB_BIT];
    assign unusedLink = ^linkPatternSelect;

    always_comb begin
        srcCtrl_next = srcCtrl_reg;
        fmtCtrl_next = fmtCtrl_reg;
        rdData_next = rdData_reg;
        if (regWr) begin
            if (regAddr == aos_pkg::SRC_CTRL_OFS) begin
                srcCtrl_next = regWrData;
            end
            if (regAddr == aos_pkg::FMT_CTRL_OFS) begin
                fmtCtrl_next = {7'h00, regWrData[aos_pkg::FMT_OB_BIT]};
            end
        end
        if (regRd) begin
            case (regAddr)
                aos_pkg::SRC_CTRL_OFS: rdData_next = srcCtrl_reg;
                aos_pkg::FMT_CTRL_OFS: rdData_next = fmtCtrl_reg;
                default: rdData_next = aos_pkg::UNMAPPED_RD;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            srcCtrl_reg <= aos_pkg::SRC_CTRL_RST;
            fmtCtrl_reg <= aos_pkg::FMT_CTRL_RST;
            rdData_reg <= aos_pkg::UNMAPPED_RD;
        end else begin
            srcCtrl_reg <= srcCtrl_next;
            fmtCtrl_reg <= fmtCtrl_next;
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData = rdData_reg;

    // ********************
    // Test tone
    // ********************
    logic [15:0] seqWord;

    aos_test_seq uSeq (
        .clk(clk),
        .rst_b(rst_b),
        .advance(coreValid),
        .restart(!patEn),
        .seqWord(seqWord)
    );

    // ********************
    // Source select and format
    // ********************
    aos_pkg::aos_pair_t out_reg;
    aos_pkg::aos_pair_t out_next;
    aos_pkg::aos_pair_t srcPair;
    logic outValid_reg;
    logic outValid_next;

    always_comb begin
        if (patEn) begin
            srcPair.chA = seqWord;
            srcPair.chB = seqWord;
        end else begin
            srcPair = coreSample;
        end
        out_next = out_reg;
        outValid_next = coreValid;
        if (coreValid) begin
            out_next = srcPair;
            if (fmtOb) begin
                out_next.chA[aos_pkg::SAMPLE_MSB] = ~srcPair.chA[aos_pkg::SAMPLE_MSB];
                out_next.chB[aos_pkg::SAMPLE_MSB] = ~srcPair.chB[aos_pkg::SAMPLE_MSB];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_reg <= '0;
            outValid_reg <= 1'b0;
        end else begin
            out_reg <= out_next;
            outValid_reg <= outValid_next;
        end
    end

    assign linkSample = out_reg;
    assign linkValid = outValid_reg;

    // ********************
    // Checks
    // ********************
    logic contPat;
    assign contPat = coreValid && patEn && !fmtOb && !unusedLink || coreValid && patEn && !fmtOb;

    sequence peakHigh;
        outValid_reg && patEn && !fmtOb && out_reg.chA == aos_pkg::SEQ_HIGH;
    endsequence

    sequence twoMore;
        contPat ##1 contPat;
    endsequence

    tone_order_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (peakHigh ##0 twoMore) |=> out_reg.chA == aos_pkg::SEQ_LOW
            && $past(out_reg.chA) == aos_pkg::SEQ_ZERO)
        else $error("test tone order broken");

    src_default_a: assert property (
        @(posedge clk)
        !rst_b |=> srcCtrl_reg == aos_pkg::SRC_CTRL_RST && !patEn)
        else $error("source control reset value wrong");

    pass_through_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && !fmtOb |=> linkValid && linkSample == $past(coreSample))
        else $error("core sample not passed through");

    pattern_both_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && patEn |=> linkValid && linkSample.chA == linkSample.chB
            && linkSample.chA == ($past(seqWord) ^ {$past(fmtOb), 15'h0000}))
        else $error("test word not inserted");

    tc_scale_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && !fmtOb && coreSample.chA == aos_pkg::TC_POS_FULL
            |=> linkSample.chA == aos_pkg::TC_POS_FULL)
        else $error("two's complement full scale wrong");

    ob_scale_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && fmtOb && coreSample.chB == aos_pkg::TC_MID
            |=> linkSample.chB == aos_pkg::OB_MID)
        else $error("offset binary mid-scale wrong");

    ob_invert_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && fmtOb |=> linkSample.chA
            == {~$past(coreSample.chA[15]), $past(coreSample.chA[14:0])})
        else $error("offset binary not MSB inverted");

    hold_idle_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        !coreValid |=> !linkValid && $stable(linkSample))
        else $error("output moved without a sample");

    read_back_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        regRd && regAddr == aos_pkg::SRC_CTRL_OFS |=> regRdData == $past(srcCtrl_reg))
        else $error("source control read back wrong");

    // Tone switched on, then the first sample taken
    sequence toneArmed;
        !patEn ##1 patEn && !coreValid;
    endsequence

    sequence firstTake;
        coreValid && patEn && !fmtOb;
    endsequence

    tone_start_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        (toneArmed ##1 firstTake) |=> linkSample.chA == aos_pkg::SEQ_ZERO
            && linkSample.chB == aos_pkg::SEQ_ZERO)
        else $error("test tone did not start at zero");

    valid_follow_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid |=> linkValid)
        else $error("taken sample not handed on");

    tc_negative_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && !fmtOb && coreSample.chA == aos_pkg::TC_NEG_FULL
            |=> linkSample.chA == aos_pkg::TC_NEG_FULL)
        else $error("two's complement negative full scale wrong");

    ob_negative_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && fmtOb && coreSample.chA == aos_pkg::TC_NEG_FULL
            |=> linkSample.chA == aos_pkg::OB_NEG_FULL)
        else $error("offset binary negative full scale wrong");

    ob_positive_a: assert property (
        @(posedge clk) disable iff (!rst_b)
        coreValid && !patEn && fmtOb && coreSample.chB == aos_pkg::TC_POS_FULL
            |=> linkSample.chB == aos_pkg::OB_POS_FULL)
        else $error("offset binary positive full scale wrong");

endmodule

// ==== testbench/aos_link_sink.sv ====
// Transport layer model that collects the sample words it is handed
`timescale 1ns/1ps
module aos_link_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Words from the block
    input wire aos_pkg::aos_pair_t linkSample,
    input wire logic linkValid
);
    aos_pkg::aos_pair_t words[$];

    // ********************
    // Capture
    // ********************
    always @(posedge clk) begin
        if (rst_b && linkValid) begin
            words.push_back(linkSample);
        end
    end
endmodule

// ==== testbench/test_aos_top.sv ====
// Self-checking bench for the output source select block
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module test_aos_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWrData = 8'h00;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regRdData;
    aos_pkg::aos_pair_t coreSample = '0;
    logic coreValid = 1'b0;
    logic [3:0] linkPatternSelect = 4'h0;
    aos_pkg::aos_pair_t linkSample;
    logic linkValid;
    int failures = 0;
    int n_compared = 0;
    logic [15:0] expQ[$];
    logic [15:0] tcCode[5] = '{16'h8000, 16'hC000, 16'h0000, 16'h4000, 16'h7FFF};
    logic [15:0] obCode[5] = '{16'h0000, 16'h4000, 16'h8000, 16'hC000, 16'hFFFF};
    logic [15:0] tone[4] = '{16'h0000, 16'(26280), 16'h0000, 16'(-26328)};

    // ********************
    // Clock and instances
    // ********************
    always #20 clk = ~clk;

    aos_top aos_top_inst (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .coreSample(coreSample),
        .coreValid(coreValid), .linkPatternSelect(linkPatternSelect),
        .linkSample(linkSample), .linkValid(linkValid));
    aos_link_sink aos_link_sink_inst (.clk(clk), .rst_b(rst_b), .linkSample(linkSample),
        .linkValid(linkValid));

    // ********************
    // Tasks
    // ********************
    task automatic complete_run();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_check(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask

    task automatic send(input logic [15:0] a, input logic [15:0] b, input logic [15:0] ea,
        input logic [15:0] eb);
        @(posedge clk);
        coreValid <= 1'b1;
        coreSample <= {a, b};
        expQ.push_back(ea);
        expQ.push_back(eb);
    endtask

    task automatic drain(input string name);
        aos_pkg::aos_pair_t w;
        logic [15:0] e;
        int k;
        @(posedge clk);
        coreValid <= 1'b0;
        k = 0;
        while (aos_link_sink_inst.words.size() * 2 < expQ.size() && k < 8) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k == 8) begin
            failures++;
            $display("Error at %0t: output missing", $time);
            complete_run();
        end
        @(posedge clk);
        #1;
        `CHK(aos_link_sink_inst.words.size() * 2, expQ.size())
        while (aos_link_sink_inst.words.size() > 0 && expQ.size() > 1) begin
            w = aos_link_sink_inst.words.pop_front();
            e = expQ.pop_front();
            `CHK(w.chA, e)
            e = expQ.pop_front();
            `CHK(w.chB, e)
        end
        aos_link_sink_inst.words.delete();
        expQ.delete();
        $display("test %s done", name);
    endtask

    // ********************
    // Sequence
    // ********************
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        reg_check(8'h70, 8'h22);
        reg_check(8'h71, 8'h00);
        reg_check(8'h55, 8'h00);
        reg_write(8'h55, 8'hFF);
        reg_check(8'h70, 8'h22);
        $display("test registers done");
        for (int i = 0; i < 5; i++) begin
            send(tcCode[i], tcCode[4 - i], tcCode[i], tcCode[4 - i]);
        end
        drain("twos complement");
        reg_write(8'h71, 8'h01);
        reg_check(8'h71, 8'h01);
        for (int i = 0; i < 5; i++) begin
            send(tcCode[i], tcCode[4 - i], obCode[i], obCode[4 - i]);
        end
        drain("offset binary");
        reg_write(8'h71, 8'h00);
        reg_write(8'h70, 8'h26);
        reg_check(8'h70, 8'h26);
        @(posedge clk);
        linkPatternSelect <= 4'hF;
        for (int i = 0; i < 6; i++) begin
            send(16'h1234, 16'h5678, tone[i % 4], tone[i % 4]);
        end
        drain("tone");
        reg_write(8'h71, 8'h01);
        linkPatternSelect <= 4'h5;
        for (int i = 6; i < 10; i++) begin
            send(16'h1234, 16'h5678, tone[i % 4] ^ 16'h8000, tone[i % 4] ^ 16'h8000);
        end
        drain("tone offset binary");
        reg_write(8'h70, 8'h22);
        reg_write(8'h71, 8'h00);
        send(16'h4000, 16'hC000, 16'h4000, 16'hC000);
        drain("tone off");
        reg_write(8'h70, 8'h26);
        send(16'h4000, 16'hC000, tone[0], tone[0]);
        send(16'h4000, 16'hC000, tone[1], tone[1]);
        drain("tone restart");
        complete_run();
    end
endmodule
